// *** shared/bgs_defines.vh ***
/*
  constants for the burst/gate/sweep sequencer: register offsets,
  field positions, reset values, encodings and timing figures.
  assumes a 100 MHz clock and an 8-bit AXI4-Lite byte address.
*/
// Operation
// - four modes: continuous, burst, triggered, gated; one at a time
// - manual press triggers once; manual hold keeps gate open; any source
// - trigger source is the external jack or the sub synthesizer
// - edge polarity picks falling or rising; in gate mode the open level
// - stop period output follows stop level: hold phase or park centre
// - non-continuous mode with reset stop level caps frequency at 1MHz
// - burst repeats mark cycles on, space cycles off, forever
// - triggered mode gives exactly mark cycles after each trigger seen while idle
// - mark count is 0.5 to 32768 cycles in half-cycle steps
// - space count is 0.5 to 32768 cycles in half-cycle steps
// - main and sub phases accept -360.0 to +360.0 degrees
// - main phase is also the resume phase after phase alignment
// - key or command phase alignment reloads main and sub phases
// - master alignment also aligns slave; alignment asked at slave rejected
// - begin above end sweeps down, begin below end sweeps up
// - changing begin or end keeps the other endpoint
// - mid frequency is linear midpoint; writing it keeps span and direction
// - marker-to-mid command acts exactly like a mid frequency write
// - span write moves endpoints around unchanged mid, keeps direction
// - marker output low while swept frequency above marker, else high
// - profiles step, linear, log; ramps as triangle or sawtooth
// - sweep time from begin to end is 5 ms to 9999 s
// - one-shot start runs exactly one sweep
// - continuous start repeats sweeps until pause or sweep off
// - pause toggle freezes a sweep with outputs held, then resumes
`ifndef BGS_DEFINES_VH
`define BGS_DEFINES_VH
`define CLK_PERIOD_NS 10
`define MS_TIME_NS 1000000
`define OFF_CTRL 8'h00
`define OFF_MARK 8'h04
`define OFF_SPACE 8'h08
`define OFF_PHASE 8'h0c
`define OFF_SUBPH 8'h10
`define OFF_BEGIN 8'h14
`define OFF_END 8'h18
`define OFF_MID 8'h1c
`define OFF_SPAN 8'h20
`define OFF_MARKER 8'h24
`define OFF_STIME 8'h28
`define OFF_CMD 8'h2c
`define OFF_STATUS 8'h30
`define OFF_FREQ 8'h34
`define CTRL_MODE 1:0
`define CTRL_SRC 2
`define CTRL_POL 3
`define CTRL_STOPRST 4
`define CTRL_PROF 6:5
`define CTRL_TRI 7
`define CTRL_LOGSH 11:8
`define CMD_ONESHOT 0
`define CMD_FREE_RUNNING_MODE 1
`define CMD_PAUSE 2
`define CMD_OFF 3
`define CMD_ALIGN 4
`define CMD_MK2MID 5
`define CMD_MANTRIG 6
`define CMD_CLRREJ 7
`define MODE_FREE_RUNNING_MODE 2'h0
`define MODE_BURST 2'h1
`define MODE_TRIG 2'h2
`define MODE_GATE 2'h3
`define PROF_STEP 2'h0
`define PROF_LIN 2'h1
`define PROF_LOG 2'h2
`define RST_CTRL 12'h000
`define RST_MARK 16'h0001
`define RST_SPACE 16'h0001
`define RST_PHASE 13'h0000
`define RST_BEGIN 32'h0000_03e8
`define RST_END 32'h0000_2710
`define RST_MARKER 32'h0000_1388
`define RST_STIME 24'h0003e8
`define STIME_MIN_MS 24'h000005
`define STIME_MAX_S 24'h00270f
`define PHASE_LIM 13'h0e10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** hdl/burst_gate_sweep_sequencer.v ***
/*
  burst/gate/trigger sequencer, phase alignment and frequency sweep
  engine with an AXI4-Lite register slave.
  assumes I_HALF_TICK pulses once per half cycle of the set main
  frequency from the oscillator core, free running even while the
  output is stopped; all other pin inputs are asynchronous.
*/
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "bgs_defines.vh"
module burst_gate_sweep_sequencer #(
  parameter MS_CYCLES = `MS_TIME_NS / `CLK_PERIOD_NS,
  parameter CW = 16
) (
  input wire I_CLOCK,
  input wire I_RST_N,
  input wire [7:0] I_AWADDR,
  input wire I_AWVALID,
  output wire O_AWREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  input wire I_WVALID,
  output wire O_WREADY,
  output wire [1:0] O_BRESP,
  output wire O_BVALID,
  input wire I_BREADY,
  input wire [7:0] I_ARADDR,
  input wire I_ARVALID,
  output wire O_ARREADY,
  output wire [31:0] O_RDATA,
  output wire [1:0] O_RRESP,
  output wire O_RVALID,
  input wire I_RREADY,
  input wire I_TRIGGER_INPUT_JACK,
  input wire I_SUB_SYNC,
  input wire I_MANUAL_TRIGGER,
  input wire I_PHASE_ALIGN_KEY,
  input wire I_SLAVE_STRAP,
  input wire I_MASTER_SYNC,
  input wire I_HALF_TICK,
  output wire O_OSC_RUN,
  output wire O_STOP_RESET,
  output wire O_FREQ_CAP_1MHZ,
  output wire O_PHASE_LOAD,
  output wire [12:0] O_MAIN_PHASE,
  output wire [12:0] O_SUB_PHASE,
  output wire O_SLAVE_SYNC,
  output wire [31:0] O_SWEEP_FREQ,
  output wire O_SWEEPING,
  output wire O_MARKER_OUTPUT
);
  localparam FW = 32;
  localparam MSW = $clog2(MS_CYCLES + 1);
  localparam integer MS_LAST_I = MS_CYCLES - 1;
  localparam [MSW-1:0] MS_LAST = MS_LAST_I[MSW-1:0];
  localparam [23:0] T_MAX = `STIME_MAX_S * 24'd1000;
  localparam [2:0] SQ_IDLE = 3'b001;
  localparam [2:0] SQ_MARK = 3'b010;
  localparam [2:0] SQ_SPACE = 3'b100;
  localparam [2:0] SW_OFF = 3'b001;
  localparam [2:0] SW_RUN = 3'b010;
  localparam [2:0] SW_HOLD = 3'b100;

  // pin synchronisers, third stage for edge detection
  wire [5:0] pins = {I_MASTER_SYNC, I_SLAVE_STRAP, I_PHASE_ALIGN_KEY,
    I_MANUAL_TRIGGER, I_SUB_SYNC, I_TRIGGER_INPUT_JACK};
  reg [5:0] s1_r;
  reg [5:0] s2_r;
  reg [5:0] s3_r;
  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s1_r <= 6'h00;
      s2_r <= 6'h00;
      s3_r <= 6'h00;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // configuration and state registers
  reg [11:0] ctrl_r;
  reg [CW-1:0] mark_r;
  reg [CW-1:0] space_r;
  reg [12:0] ph_r;
  reg [12:0] sph_r;
  reg [FW-1:0] f0_r;
  reg [FW-1:0] f1_r;
  reg [FW-1:0] mk_r;
  reg [23:0] swt_r;
  reg [7:0] cmd_r;
  reg [2:0] sq_r;
  reg [2:0] sw_r;
  reg [FW-1:0] fq_r;
  reg run_r;
  reg rej_r;
  reg cap_r;
  reg stop_r;
  reg mkr_r;
  reg pl_r;
  reg ssync_r;

  wire [1:0] mode = ctrl_r[`CTRL_MODE];
  wire [1:0] prof = ctrl_r[`CTRL_PROF];
  wire asc = f0_r <= f1_r;
  wire [FW-1:0] diff = asc ? f1_r - f0_r : f0_r - f1_r;
  wire [FW:0] sum = {1'b0, f0_r} + {1'b0, f1_r};
  wire [FW-1:0] mid = sum[FW:1];

  // new endpoints {begin,end} from mid c and span d, direction kept
  function [2*FW-1:0] recentre;
    input [FW-1:0] c;
    input [FW-1:0] d;
    input up;
    reg [FW-1:0] lo;
    reg [FW-1:0] hi;
    begin
      lo = c - (d >> 1);
      hi = lo + d;
      recentre = up ? {lo, hi} : {hi, lo};
    end
  endfunction

  // byte-lane merge for write strobes
  function [31:0] merge;
    input [31:0] o;
    input [31:0] n;
    input [3:0] s;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge[k*8 +: 8] = s[k] ? n[k*8 +: 8] : o[k*8 +: 8];
      end
    end
  endfunction

  // register readback {hit, value}, also the old value for merges
  function [32:0] rdval;
    input [7:0] a;
    begin
      case ({a[7:2], 2'b00})
        `OFF_CTRL: rdval = {1'b1, 20'h0, ctrl_r};
        `OFF_MARK: rdval = {1'b1, {(32-CW){1'b0}}, mark_r};
        `OFF_SPACE: rdval = {1'b1, {(32-CW){1'b0}}, space_r};
        `OFF_PHASE: rdval = {1'b1, 19'h0, ph_r};
        `OFF_SUBPH: rdval = {1'b1, 19'h0, sph_r};
        `OFF_BEGIN: rdval = {1'b1, f0_r};
        `OFF_END: rdval = {1'b1, f1_r};
        `OFF_MID: rdval = {1'b1, mid};
        `OFF_SPAN: rdval = {1'b1, diff};
        `OFF_MARKER: rdval = {1'b1, mk_r};
        `OFF_STIME: rdval = {1'b1, 8'h0, swt_r};
        `OFF_CMD: rdval = {1'b1, 32'h0};
        `OFF_STATUS: rdval = {1'b1, 22'h0, cap_r, rej_r, asc,
          sw_r, sq_r, run_r};
        `OFF_FREQ: rdval = {1'b1, fq_r};
        default: rdval = {1'b0, 32'h0};
      endcase
    end
  endfunction

  // phase in tenths of a degree, two's complement
  function ph_ok;
    input [12:0] v;
    reg [12:0] m;
    begin
      m = v[12] ? 13'h0000 - v : v;
      ph_ok = m <= `PHASE_LIM;
    end
  endfunction

  // axi4-lite slave: address and data taken in either order
  reg aw_ok_r;
  reg w_ok_r;
  reg bvalid_r;
  reg rvalid_r;
  reg [7:0] awa_r;
  reg [31:0] wd_r;
  reg [3:0] ws_r;
  reg [1:0] bresp_r;
  reg [1:0] rresp_r;
  reg [31:0] rdata_r;
  assign O_AWREADY = !aw_ok_r && !bvalid_r;
  assign O_WREADY = !w_ok_r && !bvalid_r;
  assign O_ARREADY = !rvalid_r;
  assign O_BVALID = bvalid_r;
  assign O_BRESP = bresp_r;
  assign O_RVALID = rvalid_r;
  assign O_RRESP = rresp_r;
  assign O_RDATA = rdata_r;
  wire wr_go = aw_ok_r && w_ok_r && !bvalid_r;
  wire [7:0] wa = {awa_r[7:2], 2'b00};
  wire [32:0] wold = rdval(awa_r);
  wire [31:0] wv = merge(wold[31:0], wd_r, ws_r);
  wire [32:0] rv = rdval(I_ARADDR);
  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      awa_r <= 8'h00;
      wd_r <= 32'h0;
      ws_r <= 4'h0;
      bresp_r <= `RESP_OKAY;
      rresp_r <= `RESP_OKAY;
      rdata_r <= 32'h0;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_ok_r <= 1'b1;
        awa_r <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_ok_r <= 1'b1;
        wd_r <= I_WDATA;
        ws_r <= I_WSTRB;
      end
      if (wr_go) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (wold[32] && wa != `OFF_STATUS && wa != `OFF_FREQ) ?
          `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_r && I_BREADY) begin
        bvalid_r <= 1'b0;
      end
      if (I_ARVALID && O_ARREADY) begin
        rvalid_r <= 1'b1;
        rdata_r <= rv[31:0];
        rresp_r <= rv[32] ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_r && I_RREADY) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // register writes; mid, span and marker copy move both endpoints
  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_r <= `RST_CTRL;
      mark_r <= `RST_MARK;
      space_r <= `RST_SPACE;
      ph_r <= `RST_PHASE;
      sph_r <= `RST_PHASE;
      f0_r <= `RST_BEGIN;
      f1_r <= `RST_END;
      mk_r <= `RST_MARKER;
      swt_r <= `RST_STIME;
      cmd_r <= 8'h00;
    end else begin
      cmd_r <= (wr_go && wa == `OFF_CMD) ? wv[7:0] : 8'h00;
      if (wr_go) begin
        case (wa)
          `OFF_CTRL: ctrl_r <= wv[11:0];
          `OFF_MARK: mark_r <= wv[CW-1:0];
          `OFF_SPACE: space_r <= wv[CW-1:0];
          `OFF_PHASE: if (ph_ok(wv[12:0])) ph_r <= wv[12:0];
          `OFF_SUBPH: if (ph_ok(wv[12:0])) sph_r <= wv[12:0];
          `OFF_BEGIN: f0_r <= wv;
          `OFF_END: f1_r <= wv;
          `OFF_MID: {f0_r, f1_r} <= recentre(wv, diff, asc);
          `OFF_SPAN: {f0_r, f1_r} <= recentre(mid, wv, asc);
          `OFF_MARKER: mk_r <= wv;
          `OFF_STIME: begin
            if (wv[31:24] == 8'h00 && wv[23:0] >= `STIME_MIN_MS &&
                wv[23:0] <= T_MAX) begin
              swt_r <= wv[23:0];
            end
          end
          `OFF_CMD: begin
            if (wv[`CMD_MK2MID]) begin
              {f0_r, f1_r} <= recentre(mk_r, diff, asc);
            end
          end
          default: ;
        endcase
      end
    end
  end

  // trigger and gate derivation
  wire src_lvl = ctrl_r[`CTRL_SRC] ? s2_r[1] : s2_r[0];
  wire src_prv = ctrl_r[`CTRL_SRC] ? s3_r[1] : s3_r[0];
  wire rise = src_lvl && !src_prv;
  wire fall = !src_lvl && src_prv;
  wire ext_evt = ctrl_r[`CTRL_POL] ? rise : fall;
  wire man_press = s2_r[2] && !s3_r[2];
  wire trig_evt = ext_evt || man_press || cmd_r[`CMD_MANTRIG];
  wire gate_lvl = (ctrl_r[`CTRL_POL] ? src_lvl : !src_lvl) ||
    s2_r[2];

  // mark/space sequencer counting half cycles
  reg [CW-1:0] cnt_r;
  reg [1:0] mq_r;
  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sq_r <= SQ_IDLE;
      cnt_r <= {CW{1'b0}};
      mq_r <= `MODE_FREE_RUNNING_MODE;
      run_r <= 1'b1;
    end else begin
      mq_r <= mode;
      run_r <= mode == `MODE_FREE_RUNNING_MODE || sq_r == SQ_MARK ||
        (mode == `MODE_GATE && gate_lvl);
      if (mode != mq_r) begin
        sq_r <= SQ_IDLE;
        cnt_r <= {CW{1'b0}};
      end else begin
        case (sq_r)
          SQ_IDLE: begin
            if (mode == `MODE_BURST ||
                (mode == `MODE_TRIG && trig_evt)) begin
              sq_r <= SQ_MARK;
              cnt_r <= {CW{1'b0}};
            end
          end
          SQ_MARK: begin
            // new triggers are not looked at here
            if (I_HALF_TICK) begin
              if (cnt_r == mark_r) begin
                cnt_r <= {CW{1'b0}};
                sq_r <= mode == `MODE_BURST ? SQ_SPACE :
                  SQ_IDLE;
              end else begin
                cnt_r <= cnt_r + 1'b1;
              end
            end
          end
          SQ_SPACE: begin
            if (I_HALF_TICK) begin
              if (cnt_r == space_r) begin
                cnt_r <= {CW{1'b0}};
                sq_r <= SQ_MARK;
              end else begin
                cnt_r <= cnt_r + 1'b1;
              end
            end
          end
          default: sq_r <= SQ_IDLE;
        endcase
      end
    end
  end

  // stop level, frequency cap and phase alignment
  wire strap = s2_r[4];
  wire key_press = s2_r[3] && !s3_r[3];
  wire master_evt = s2_r[5] ^ s3_r[5];
  wire local_req = cmd_r[`CMD_ALIGN] || key_press;
  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      stop_r <= 1'b0;
      cap_r <= 1'b0;
      rej_r <= 1'b0;
      pl_r <= 1'b0;
      ssync_r <= 1'b0;
    end else begin
      stop_r <= ctrl_r[`CTRL_STOPRST] && mode != `MODE_FREE_RUNNING_MODE;
      cap_r <= ctrl_r[`CTRL_STOPRST] && mode != `MODE_FREE_RUNNING_MODE;
      // set wins over clear
      rej_r <= (strap && local_req) ||
        (rej_r && !cmd_r[`CMD_CLRREJ]);
      pl_r <= strap ? master_evt : local_req;
      ssync_r <= ssync_r ^ (!strap && local_req);
    end
  end

  // sweep engine: legs of swt_r ms, ramps at most one unit per clock
  reg [MSW-1:0] ms_r;
  reg [23:0] t_r;
  reg [FW+7:0] err_r;
  reg back_r;
  reg free_running_mode_r;
  wire is_step = prof == `PROF_STEP;
  wire ms_end = ms_r == MS_LAST;
  wire leg_end = ms_end && t_r >= swt_r - 24'd1;
  wire [FW-1:0] tgt = back_r ? f0_r : f1_r;
  wire [FW-1:0] inc = prof == `PROF_LOG ?
    fq_r >> ctrl_r[`CTRL_LOGSH] : diff;
  wire [FW+7:0] tq = {{(FW-16){1'b0}}, swt_r};
  wire last = (is_step || ctrl_r[`CTRL_TRI]) ? back_r : 1'b1;
  wire go = cmd_r[`CMD_ONESHOT] || cmd_r[`CMD_FREE_RUNNING_MODE];
  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sw_r <= SW_OFF;
      fq_r <= `RST_BEGIN;
      ms_r <= {MSW{1'b0}};
      t_r <= 24'h0;
      err_r <= {(FW+8){1'b0}};
      back_r <= 1'b0;
      free_running_mode_r <= 1'b0;
      mkr_r <= 1'b1;
    end else begin
      mkr_r <= !(sw_r != SW_OFF && fq_r > mk_r);
      if (cmd_r[`CMD_OFF]) begin
        sw_r <= SW_OFF;
      end else if (go) begin
        sw_r <= SW_RUN;
        free_running_mode_r <= cmd_r[`CMD_FREE_RUNNING_MODE];
        fq_r <= f0_r;
        ms_r <= {MSW{1'b0}};
        t_r <= 24'h0;
        err_r <= {(FW+8){1'b0}};
        back_r <= 1'b0;
      end else begin
        case (sw_r)
          SW_OFF: ;
          SW_HOLD: if (cmd_r[`CMD_PAUSE]) sw_r <= SW_RUN;
          SW_RUN: begin
            if (cmd_r[`CMD_PAUSE]) begin
              sw_r <= SW_HOLD;
            end else begin
              ms_r <= ms_end ? {MSW{1'b0}} : ms_r + 1'b1;
              if (leg_end) begin
                t_r <= 24'h0;
                err_r <= {(FW+8){1'b0}};
                if (!last) begin
                  back_r <= 1'b1;
                  fq_r <= f1_r;
                end else if (free_running_mode_r) begin
                  back_r <= 1'b0;
                  fq_r <= f0_r;
                end else begin
                  sw_r <= SW_OFF;
                  if (!is_step) fq_r <= tgt;
                end
              end else if (ms_end) begin
                t_r <= t_r + 24'd1;
                if (!is_step) err_r <= err_r + {8'h00, inc};
              end else if (!is_step && err_r >= tq && fq_r != tgt) begin
                err_r <= err_r - tq;
                fq_r <= fq_r < tgt ? fq_r + 1'b1 : fq_r - 1'b1;
              end
            end
          end
          default: sw_r <= SW_OFF;
        endcase
      end
    end
  end

  assign O_OSC_RUN = run_r;
  assign O_STOP_RESET = stop_r;
  assign O_FREQ_CAP_1MHZ = cap_r;
  assign O_PHASE_LOAD = pl_r;
  assign O_MAIN_PHASE = ph_r;
  assign O_SUB_PHASE = sph_r;
  assign O_SLAVE_SYNC = ssync_r;
  assign O_SWEEP_FREQ = fq_r;
  assign O_SWEEPING = sw_r != SW_OFF;
  assign O_MARKER_OUTPUT = mkr_r;
endmodule // burst_gate_sweep_sequencer
`default_nettype wire

// *** verif/bgs_sva.sv ***
/*
  checker for the sequencer: bus handshakes, phase reload pulse,
  marker output and frequency cap against the top module's ports.
  assumes one clock domain and an active low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bgs_sva (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic O_PHASE_LOAD,
  input wire logic O_MARKER_OUTPUT,
  input wire logic O_SWEEPING,
  input wire logic O_FREQ_CAP_1MHZ,
  input wire logic O_STOP_RESET
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_N);
  // write answer seen two edges after both halves taken together
  property p_b_after;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID;
  endproperty
  a_b_after: assert property (p_b_after) else $error("write answer missing");
  // response stands until taken
  property p_b_hold;
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  // no new write taken while an answer is pending
  property p_aw_block;
    O_BVALID |-> !O_AWREADY && !O_WREADY;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken early");
  // read answer one edge after the address is taken
  property p_r_after;
    I_ARVALID && O_ARREADY |=> O_RVALID;
  endproperty
  a_r_after: assert property (p_r_after) else $error("read answer missing");
  // read data stands until taken
  property p_r_hold;
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  // one read at a time
  property p_ar_block;
    O_RVALID |-> !O_ARREADY;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken early");
  // phase reload is a single cycle pulse
  property p_pl_pulse;
    $rose(O_PHASE_LOAD) |=> !O_PHASE_LOAD;
  endproperty
  a_pl_pulse: assert property (p_pl_pulse) else $error("reload long");
  // marker low only during a sweep
  property p_mkr;
    !O_MARKER_OUTPUT |-> O_SWEEPING || $past(O_SWEEPING);
  endproperty
  a_mkr: assert property (p_mkr) else $error("marker low idle");
  // frequency cap only with reset stop level
  property p_cap;
    O_FREQ_CAP_1MHZ |-> O_STOP_RESET;
  endproperty
  a_cap: assert property (p_cap) else $error("cap without reset");
endmodule // bgs_sva
bind burst_gate_sweep_sequencer bgs_sva i_sva (.I_CLOCK(I_CLOCK),
  .I_RST_N(I_RST_N), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
  .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
  .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID),
  .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY), .O_PHASE_LOAD(O_PHASE_LOAD),
  .O_MARKER_OUTPUT(O_MARKER_OUTPUT), .O_SWEEPING(O_SWEEPING),
  .O_FREQ_CAP_1MHZ(O_FREQ_CAP_1MHZ), .O_STOP_RESET(O_STOP_RESET));
`default_nettype wire

// *** verif/bgs_far_side.sv ***
/*
  far side model: trigger jack, sub synthesizer sync, oscillator
  half tick and master unit link toggle.
  assumes the bench clock; the bench sets jack level and link toggle.
*/
`timescale 1ns/1ps
`default_nettype none
module bgs_far_side (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ext_lvl,
  input wire logic i_tog,
  output logic o_jack,
  output logic o_sub_sync,
  output logic o_half_tick,
  output logic o_master_sync
);
  logic [1:0] div_r;
  logic [3:0] sub_r;
  // free running half cycle and sub synthesizer dividers
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r <= 2'h0;
      sub_r <= 4'h0;
    end else begin
      div_r <= div_r + 2'h1;
      sub_r <= sub_r + 4'h1;
    end
  end
  assign o_half_tick = (div_r == 2'h3); // one pulse every 4 cycles
  assign o_sub_sync = sub_r[3];
  assign o_jack = i_ext_lvl;
  assign o_master_sync = i_tog;
endmodule // bgs_far_side
`default_nettype wire

// *** verif/tb_burst_gate_sweep_sequencer.sv ***
/*
  self-checking bench: register access, sweep arithmetic, trigger,
  gate, burst, phase alignment and sweep runs.
  assumes MS_CYCLES of 10 and a half tick every 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bgs_defines.vh"
module tb_burst_gate_sweep_sequencer;
  logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, external_source = 0, key = 0, akey = 0;
  logic strap = 0, mtog = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rv, fz;
  logic [3:0] wstrb = 0;
  logic [1:0] rr;
  wire awrdy, wrdy, bvld, arrdy, rvld, jack, subs, tick, msync;
  wire run, srst, cap, pload, slsync, swp, marker_freq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, freq;
  wire [12:0] mph, sph;
  int error_cnt = 0, n_checks = 0, pl_cnt = 0, hi_cnt = 0, mk_lo = 0, pl;
  burst_gate_sweep_sequencer #(.MS_CYCLES(10)) i_dut (.I_CLOCK(clk),
    .I_RST_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awrdy), .I_WDATA(wdata), .I_WSTRB(wstrb),
    .I_WVALID(wvalid), .O_WREADY(wrdy), .O_BRESP(bresp), .O_BVALID(bvld),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arrdy), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvld),
    .I_RREADY(rready), .I_TRIGGER_INPUT_JACK(jack), .I_SUB_SYNC(subs),
    .I_MANUAL_TRIGGER(key), .I_PHASE_ALIGN_KEY(akey),
    .I_SLAVE_STRAP(strap), .I_MASTER_SYNC(msync), .I_HALF_TICK(tick),
    .O_OSC_RUN(run), .O_STOP_RESET(srst), .O_FREQ_CAP_1MHZ(cap),
    .O_PHASE_LOAD(pload), .O_MAIN_PHASE(mph), .O_SUB_PHASE(sph),
    .O_SLAVE_SYNC(slsync), .O_SWEEP_FREQ(freq), .O_SWEEPING(swp),
    .O_MARKER_OUTPUT(marker_freq));
  bgs_far_side i_far (.i_clk(clk), .i_rst_n(rst_n), .i_ext_lvl(external_source),
    .i_tog(mtog), .o_jack(jack), .o_sub_sync(subs), .o_half_tick(tick),
    .o_master_sync(msync));
  // clock
  initial begin
    forever #5 clk = ~clk;
  end
  // event counters sampled mid cycle
  always @(negedge clk) begin
    if (pload === 1'b1) pl_cnt++;
    if (run === 1'b1) hi_cnt++;
    if (marker_freq === 1'b0) mk_lo++;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task conclude;
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // write: address and data together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(negedge clk);
      ah = awvalid & awrdy; wh = wvalid & wrdy; bh = bvld; rr = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) break;
    end
    bready <= 1'b0;
    if (bh !== 1'b1) error_cnt++;
  endtask
  task rd(input logic [7:0] a);
    logic ah, rh;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(negedge clk);
      ah = arvalid & arrdy; rh = rvld; rv = rdata; rr = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
      if (rh) break;
    end
    rready <= 1'b0;
    if (rh !== 1'b1) error_cnt++;
  endtask
  task wend;
    repeat (300) begin
      @(negedge clk);
      if (swp !== 1'b1) break;
    end
  endtask
  // hang guard
  initial begin
    #400000;
    error_cnt++;
    conclude;
  end
  initial begin
    cyc(2);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(run, 1'b1);
    chk(freq, `RST_BEGIN);
    rd(`OFF_END); chk(rv, `RST_END);
    rd(`OFF_MARKER); chk(rv, `RST_MARKER);
    rd(`OFF_MID); chk(rv, 32'd5500);
    rd(`OFF_SPAN); chk(rv, 32'd9000);
    rd(8'h3c); chk(rr, `RESP_SLVERR);
    wr(`OFF_STATUS, 32'h0); chk(rr, `RESP_SLVERR);
    wr(`OFF_MID, 32'd6000);
    rd(`OFF_BEGIN); chk(rv, 32'd1500);
    rd(`OFF_END); chk(rv, 32'd10500);
    wr(`OFF_SPAN, 32'd2000);
    rd(`OFF_BEGIN); chk(rv, 32'd5000);
    rd(`OFF_END); chk(rv, 32'd7000);
    wr(`OFF_BEGIN, 32'd9000);
    rd(`OFF_END); chk(rv, 32'd7000);
    rd(`OFF_STATUS); chk(rv[7], 1'b0);
    wr(`OFF_CMD, 32'h20);
    rd(`OFF_BEGIN); chk(rv, 32'd6000);
    rd(`OFF_END); chk(rv, 32'd4000);
    // phase limits, negative full turn then one step beyond the positive limit
    wr(`OFF_PHASE, 32'h11f0);
    wr(`OFF_PHASE, 32'h0e11);
    rd(`OFF_PHASE); chk(rv, 32'h11f0);
    chk(mph, 13'h11f0);
    wr(`OFF_SUBPH, 32'h0e10); chk(sph, 13'h0e10);
    wr(`OFF_STIME, 32'd4);
    rd(`OFF_STIME); chk(rv, 32'h3e8);
    wr(`OFF_STIME, 32'd5);
    rd(`OFF_STIME); chk(rv, 32'd5);
    // alignment at master, then as slave
    pl = pl_cnt; wr(`OFF_CMD, 32'h10); cyc(5);
    chk(slsync, 1'b1);
    akey <= 1'b1; cyc(8);
    chk(pl_cnt - pl, 2);
    akey <= 1'b0; strap <= 1'b1; cyc(6);
    pl = pl_cnt; wr(`OFF_CMD, 32'h10); cyc(5);
    chk(pl_cnt - pl, 0);
    chk(slsync, 1'b0);
    rd(`OFF_STATUS); chk(rv[8], 1'b1);
    mtog <= 1'b1; cyc(8);
    chk(pl_cnt - pl, 1);
    strap <= 1'b0; wr(`OFF_CMD, 32'h80);
    rd(`OFF_STATUS); chk(rv[8], 1'b0);
    // stop level and frequency cap
    wr(`OFF_CTRL, 32'h12); cyc(2);
    chk(srst, 1'b1);
    chk(cap, 1'b1);
    wr(`OFF_CTRL, 32'h10); cyc(2); chk(cap, 1'b0);
    // triggered: 4 half cycles, retrigger inside mark ignored
    wr(`OFF_MARK, 32'd3); wr(`OFF_CTRL, 32'h0a); cyc(6);
    chk(run, 1'b0);
    hi_cnt = 0; external_source <= 1'b1; cyc(8); external_source <= 1'b0; cyc(4);
    external_source <= 1'b1; cyc(4); external_source <= 1'b0; cyc(40);
    chk(hi_cnt >= 12 && hi_cnt <= 20, 1'b1);
    hi_cnt = 0; wr(`OFF_CMD, 32'h40); cyc(40);
    chk(hi_cnt >= 12 && hi_cnt <= 20, 1'b1);
    // internal source: sub synthesizer edges trigger, jack idle
    wr(`OFF_CTRL, 32'h0e); hi_cnt = 0; cyc(40);
    chk(hi_cnt > 0, 1'b1);
    // gate, rising then falling polarity and manual hold, then burst duty
    wr(`OFF_CTRL, 32'h0b); external_source <= 1'b1; cyc(6); chk(run, 1'b1);
    external_source <= 1'b0; cyc(6); chk(run, 1'b0);
    key <= 1'b1; cyc(6); chk(run, 1'b1);
    key <= 1'b0; wr(`OFF_CTRL, 32'h03); cyc(6); chk(run, 1'b1);
    wr(`OFF_CTRL, 32'h01); cyc(4); hi_cnt = 0; cyc(96);
    chk(hi_cnt > 50 && hi_cnt < 84, 1'b1);
    // linear sawtooth single sweep through the marker, then a step single sweep
    wr(`OFF_CTRL, 32'h20); wr(`OFF_BEGIN, 32'd1000);
    wr(`OFF_END, 32'd1040); wr(`OFF_MARKER, 32'd1020);
    rd(`OFF_STATUS); chk(rv[7], 1'b1);
    mk_lo = 0; wr(`OFF_CMD, 32'h01); cyc(3); chk(swp, 1'b1);
    wend; chk(swp, 1'b0);
    chk(freq, 32'd1040);
    chk(mk_lo > 0, 1'b1);
    cyc(1); mk_lo = 0; cyc(5); chk(mk_lo, 0);
    wr(`OFF_CTRL, 32'h00); wr(`OFF_CMD, 32'h01); cyc(25);
    chk(freq, 32'd1000);
    cyc(50); chk(freq, 32'd1040);
    wend;
    // log triangle: still running past one leg, ends back at begin
    wr(`OFF_CTRL, 32'hc0); wr(`OFF_CMD, 32'h01); cyc(60);
    chk(swp, 1'b1);
    wend; chk(freq, 32'd1000);
    // continuous run, pause, resume, off
    wr(`OFF_CTRL, 32'h20); wr(`OFF_CMD, 32'h02); cyc(20);
    wr(`OFF_CMD, 32'h04); cyc(3); fz = freq; cyc(30);
    chk(freq, fz);
    chk(swp, 1'b1);
    wr(`OFF_CMD, 32'h04); cyc(10); chk(freq !== fz, 1'b1);
    cyc(60); chk(swp, 1'b1);
    wr(`OFF_CMD, 32'h08); cyc(3); chk(swp, 1'b0);
    conclude;
  end
endmodule // tb_burst_gate_sweep_sequencer
`default_nettype wire
